// [rtl/frc_device.sv]
// device end: volatile read-behaviour config register and read engine
// runs on the link clock; host keeps sclk running and frames with cs_n
//
// Contract
// (RULE1) dummy count comes from config bits 7:4
// (RULE2) codes 0000 and 1111 both give default
// (RULE3) host programs dummies enough for its clock
// (RULE4) config bit 3 enables execute-in-place
// (RULE5) feature digit 2 or 4 forces execute-in-place
// (RULE6) wrap field: 16, 32, 64 bytes, sequential
// (RULE7) wrap inside aligned block, repeating forever
// (RULE8) wrap start is the three-byte address
// (RULE9) written settings act at once
// (RULE10) config reached only by its two commands
// (RULE11) protocol bits pick dual or quad at power-up
// (RULE12) host picks dummies per read variant
// (RULE13) host keeps clock within characterized limit
// (RULE14) sequential read rolls over whole array
//
// Register access over AHB-Lite and the register addresses were decided locally.
`timescale 1ns/100ps
module frc_device #(
  parameter int FEATURE_DIGIT = 1
) (
  frc_link_if.dev                    LINK,
  input  wire logic                  SYS_RST_I,
  input  wire logic [1:0]            NV_PROTO_I,
  input  wire logic [7:0]            MEM_DATA_I,
  output logic      [23:0]           MEM_ADDR_O,
  output logic      [3:0]            DUMMY_CYCLES_O,
  output logic                       XIP_ACTIVE_O,
  output logic      [1:0]            WRAP_MODE_O,
  output frc_pkg::frc_proto_t        PROTOCOL_O
);

  typedef enum logic [2:0] {S_CMD, S_ADDR, S_DUMMY, S_DATA, S_WR, S_IDLE} frc_dst_t;

  typedef struct packed {
    frc_dst_t            st;
    logic [4:0]          cnt;
    logic [23:0]         sh;
    logic [7:0]          tx;
    logic                miso;
    logic                oe;
    logic [7:0]          vcr;
    logic [3:0]          dummy;
    logic                execute_in_place_enable;
    logic                xip_armed;
    logic                rd_vcr;
    logic [23:0]         addr;
    frc_pkg::frc_proto_t proto;
  } frc_dev_t;

  localparam int   DUMMY_MSB  = frc_pkg::DUMMY_MSB;
  localparam int   DUMMY_LSB  = frc_pkg::DUMMY_LSB;
  localparam int   XIP_BIT    = frc_pkg::XIP_BIT;
  localparam int   WRAP_MSB   = frc_pkg::WRAP_MSB;
  // forced variants leave reset already in execute-in-place
  localparam logic xip_forced = (FEATURE_DIGIT == frc_pkg::XIP_DIGIT_A) ||
                                (FEATURE_DIGIT == frc_pkg::XIP_DIGIT_B);

  localparam frc_dev_t RST_VAL = '{
    st:        S_CMD,
    cnt:       5'h0,
    sh:        24'h00_0000,
    tx:        8'h00,
    miso:      1'b1,
    oe:        1'b0,
    vcr:       frc_pkg::VCR_RESET,
    dummy:     frc_pkg::DUMMY_DEFAULT,
    execute_in_place_enable:       xip_forced,
    xip_armed: 1'b0,
    rd_vcr:    1'b0,
    addr:      24'h00_0000,
    proto:     frc_pkg::FRC_PROTO_EXT
  };

  frc_dev_t q;
  frc_dev_t d;

  function automatic logic [3:0] eff_dummy(input logic [3:0] code);
    if (code == frc_pkg::DUMMY_ZERO || code == frc_pkg::DUMMY_ALL)
      return frc_pkg::DUMMY_DEFAULT; // RULE2
    return code;
  endfunction

  // next byte address; wrap keeps the aligned block, sequential rolls 24 bits
  function automatic logic [23:0] next_addr(input logic [23:0] a, input logic [1:0] wrap);
    logic [23:0] m;
    m = 24'h00_0000;
    case (wrap)
      frc_pkg::WRAP_16: m = frc_pkg::MASK_16; // RULE6
      frc_pkg::WRAP_32: m = frc_pkg::MASK_32; // RULE6
      frc_pkg::WRAP_64: m = frc_pkg::MASK_64; // RULE6
      default:          m = 24'h00_0000;
    endcase
    if (m == 24'h00_0000)
      return a + frc_pkg::ADDR_ONE; // RULE14
    return (a & ~m) | ((a + frc_pkg::ADDR_ONE) & m); // RULE7
  endfunction

  function automatic frc_pkg::frc_proto_t decode_proto(input logic [1:0] nv);
    // nv[1] is the quad bit, nv[0] the dual bit; zero enables
    if (!nv[1])
      return frc_pkg::FRC_PROTO_QUAD; // RULE11
    if (!nv[0])
      return frc_pkg::FRC_PROTO_DUAL; // RULE11
    return frc_pkg::FRC_PROTO_EXT;
  endfunction

  always_comb
  begin
    logic [7:0]  byte_v;
    logic [23:0] in_v;
    byte_v = 8'h00;
    in_v   = {q.sh[22:0], LINK.mosi};
    d      = q;
    if (LINK.cs_n)
    begin
      // between frames: an armed device expects the address first
      d.st     = q.xip_armed ? S_ADDR : S_CMD;
      d.cnt    = 5'h0;
      d.oe     = 1'b0;
      d.miso   = 1'b1;
      d.rd_vcr = 1'b0;
    end
    else
    begin
      case (q.st)
        S_CMD:
        begin
          d.sh  = in_v;
          d.cnt = q.cnt + 5'h1;
          if (q.cnt == 5'(frc_pkg::CMD_BITS - 1))
          begin
            d.cnt = 5'h0;
            case (in_v[7:0])
              frc_pkg::CMD_RD_VCR: // RULE10
              begin
                d.st     = S_DATA;
                d.rd_vcr = 1'b1;
                d.oe     = 1'b1;
                d.miso   = q.vcr[7];
                d.tx     = {q.vcr[6:0], 1'b0};
              end
              frc_pkg::CMD_WR_VCR:  d.st = S_WR; // RULE10
              frc_pkg::CMD_FAST_RD: d.st = S_ADDR;
              default:              d.st = S_IDLE;
            endcase
          end
        end
        S_ADDR:
        begin
          d.sh  = in_v;
          d.cnt = q.cnt + 5'h1;
          if (q.cnt == 5'(frc_pkg::ADDR_BITS - 1))
          begin
            d.cnt       = 5'h0;
            d.addr      = in_v; // RULE8
            d.st        = S_DUMMY;
            d.xip_armed = q.execute_in_place_enable; // RULE4
          end
        end
        S_DUMMY:
        begin
          d.cnt = q.cnt + 5'h1;
          if (q.cnt == {1'b0, q.dummy} - 5'h1) // RULE1
          begin
            d.cnt  = 5'h0;
            d.st   = S_DATA;
            d.oe   = 1'b1;
            d.miso = MEM_DATA_I[7];
            d.tx   = {MEM_DATA_I[6:0], 1'b0};
            d.addr = next_addr(q.addr, q.vcr[WRAP_MSB:0]);
          end
        end
        S_DATA:
        begin
          if (q.cnt == 5'(frc_pkg::DATA_BITS - 1))
          begin
            // config reads repeat the register for as long as cs_n stays low
            byte_v = q.rd_vcr ? q.vcr : MEM_DATA_I;
            d.cnt  = 5'h0;
            d.miso = byte_v[7];
            d.tx   = {byte_v[6:0], 1'b0};
            if (!q.rd_vcr)
              d.addr = next_addr(q.addr, q.vcr[WRAP_MSB:0]); // RULE7
          end
          else
          begin
            d.cnt  = q.cnt + 5'h1;
            d.miso = q.tx[7];
            d.tx   = {q.tx[6:0], 1'b0};
          end
        end
        S_WR:
        begin
          d.sh  = in_v;
          d.cnt = q.cnt + 5'h1;
          if (q.cnt == 5'(frc_pkg::DATA_BITS - 1))
          begin
            d.vcr = in_v[7:0] & frc_pkg::VCR_RSVD_MASK; // RULE9
            d.st  = S_IDLE;
          end
        end
        S_IDLE:  d.cnt = 5'h0;
        default: d.st  = S_IDLE;
      endcase
    end
    // derived settings follow the register in the same edge
    d.dummy = eff_dummy(d.vcr[DUMMY_MSB:DUMMY_LSB]); // RULE1
    d.execute_in_place_enable   = xip_forced || !d.vcr[XIP_BIT]; // RULE5
    if (!d.execute_in_place_enable)
      d.xip_armed = 1'b0; // RULE4
  end

  always_ff @(posedge LINK.sclk)
  begin
    if (SYS_RST_I)
    begin
      q       <= RST_VAL;
      // strap caught while reset is applied; synchronous, so no async load
      q.proto <= decode_proto(NV_PROTO_I); // RULE11
    end
    else
      q <= d;
  end

  assign LINK.miso_o    = q.miso;
  assign LINK.miso_oe   = q.oe;
  assign MEM_ADDR_O     = q.addr;
  assign DUMMY_CYCLES_O = q.dummy;
  assign XIP_ACTIVE_O   = q.execute_in_place_enable;
  assign WRAP_MODE_O    = q.vcr[WRAP_MSB:0];
  assign PROTOCOL_O     = q.proto;

endmodule // frc_device

// [rtl/frc_host.sv]
// host end: ahb-lite register slave that runs config and fast-read frames
// assumes one ahb master, single word transfers; sclk is derived and runs free
`timescale 1ns/100ps
module frc_host #(
  parameter int HALF_DIV = 6
) (
  input  wire logic        CLOCK_I,
  input  wire logic        SYS_RST_I,
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic      [31:0] HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  frc_link_if.host         LINK
);

  typedef struct packed {
    logic        we;
    logic [7:0]  wa;
    logic [31:0] hrdata;
    logic        hready;
    logic [1:0]  op;
    logic [1:0]  len;
    logic [3:0]  hdummy;
    logic [23:0] addr;
    logic [7:0]  wdata;
    logic [31:0] rdata;
    logic [31:0] rx;
    logic        busy;
    logic        rd;
    logic [7:0]  total;
    logic [7:0]  samp;
    logic [7:0]  edges;
    logic [39:0] tx;
    logic [2:0]  sync;
    logic        miso_f;
    logic [7:0]  div;
    logic        sclk;
    logic        cs_n;
    logic        mosi;
  } frc_host_t;

  frc_host_t q;
  frc_host_t d;

  always_comb
  begin
    logic       rise;
    logic       fall;
    logic [7:0] outb;
    logic [7:0] dum;
    logic [7:0] inb;
    rise = 1'b0;
    fall = 1'b0;
    outb = 8'h00;
    dum  = 8'h00;
    inb  = 8'h00;
    d    = q;
    d.sync = {q.sync[1:0], LINK.miso};
    if (q.sync[2] == q.sync[1])
      d.miso_f = q.sync[2];
    // free running divider; the device also needs edges to leave reset
    d.div = q.div + 8'h1;
    if (q.div == 8'(HALF_DIV - 1))
    begin
      d.div  = 8'h0;
      d.sclk = !q.sclk;
      rise   = !q.sclk;
      fall   = q.sclk;
    end
    if (rise && !q.cs_n)
      d.edges = q.edges + 8'h1;
    if (fall && q.busy && q.cs_n && q.edges == 8'h0)
    begin
      d.cs_n = 1'b0;
      d.mosi = q.tx[39];
      d.tx   = {q.tx[38:0], 1'b0};
    end
    else if (fall && !q.cs_n)
    begin
      // sample at the falling edge: a half period covers the synchroniser
      if (q.rd && q.edges > q.samp)
        d.rx = {q.rx[30:0], q.miso_f}; // RULE3
      if (q.edges == q.total)
      begin
        d.cs_n  = 1'b1;
        d.busy  = 1'b0;
        d.edges = 8'h0;
        d.rdata = d.rx;
      end
      else
      begin
        d.mosi = q.tx[39];
        d.tx   = {q.tx[38:0], 1'b0};
      end
    end
    // ahb data phase write
    if (q.we)
    begin
      case (q.wa)
        frc_pkg::REG_CTRL:
          if (!q.busy && HWDATA_I[frc_pkg::CTRL_START])
          begin
            d.op     = HWDATA_I[frc_pkg::CTRL_OP_LSB +: 2];
            d.len    = HWDATA_I[frc_pkg::CTRL_LEN_LSB +: 2];
            d.hdummy = HWDATA_I[frc_pkg::CTRL_DUM_LSB +: 4];
            d.busy   = 1'b1;
            d.rx     = 32'h0000_0000;
            d.edges  = 8'h0;
            inb      = {3'h0, d.len, 3'h0} + 8'(frc_pkg::DATA_BITS);
            case (d.op)
              frc_pkg::OP_WR_VCR: // RULE10
              begin
                outb = 8'(frc_pkg::CMD_BITS + frc_pkg::DATA_BITS);
                inb  = 8'h0;
                d.tx = {frc_pkg::CMD_WR_VCR, q.wdata, 24'h00_0000};
              end
              frc_pkg::OP_FAST_RD:
              begin
                outb = 8'(frc_pkg::CMD_BITS + frc_pkg::ADDR_BITS);
                dum  = {4'h0, d.hdummy}; // RULE12
                d.tx = {frc_pkg::CMD_FAST_RD, q.addr, 8'h00};
              end
              default: // RULE10
              begin
                outb = 8'(frc_pkg::CMD_BITS);
                d.tx = {frc_pkg::CMD_RD_VCR, 32'h0000_0000};
              end
            endcase
            d.rd    = (inb != 8'h0);
            d.samp  = outb + dum - 8'h1;
            d.total = d.rd ? outb + dum + inb - 8'h1 : outb;
          end
        frc_pkg::REG_ADDR:  d.addr  = HWDATA_I[23:0];
        frc_pkg::REG_WDATA: d.wdata = HWDATA_I[7:0];
        default:            d.wdata = q.wdata;
      endcase
    end
    // address phase; read data is built from the updated copy
    d.we = 1'b0;
    if (HSEL_I && HREADY_I && HTRANS_I[1])
    begin
      d.we = HWRITE_I;
      d.wa = HADDR_I[7:0];
      if (!HWRITE_I)
      begin
        case (HADDR_I[7:0])
          frc_pkg::REG_CTRL:   d.hrdata = {20'h0_0000, d.hdummy, 3'h0, d.len, d.op, 1'b0};
          frc_pkg::REG_ADDR:   d.hrdata = {8'h00, d.addr};
          frc_pkg::REG_WDATA:  d.hrdata = {24'h00_0000, d.wdata};
          frc_pkg::REG_STATUS: d.hrdata = {31'h0000_0000, d.busy};
          frc_pkg::REG_RDATA:  d.hrdata = d.rdata;
          default:             d.hrdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (SYS_RST_I)
    begin
      q        <= '0;
      q.hready <= 1'b1;
      q.cs_n   <= 1'b1;
      q.sync   <= 3'h7;
      q.miso_f <= 1'b1;
    end
    else
      q <= d;
  end

  assign HRDATA_O    = q.hrdata;
  assign HREADYOUT_O = q.hready;
  assign HRESP_O     = 1'b0;
  assign LINK.sclk   = q.sclk;
  assign LINK.cs_n   = q.cs_n;
  assign LINK.mosi   = q.mosi;

endmodule // frc_host

// [rtl/frc_link_if.sv]
// serial link between the flash config device end and the host end
// the bench instantiates it; miso idles high when nobody drives it
`timescale 1ns/100ps
interface frc_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  logic miso;
  assign miso = miso_oe ? miso_o : 1'b1;
  modport dev  (input sclk, input cs_n, input mosi, input miso, output miso_o, output miso_oe);
  modport host (output sclk, output cs_n, output mosi, input miso);
endinterface

// [rtl/frc_pkg.sv]
// constants shared by the read-config flash device end and its host end
// assumes single-line serial framing, mode 0, msb first
package frc_pkg;
  localparam logic [7:0]  CMD_RD_VCR    = 8'h85;
  localparam logic [7:0]  CMD_WR_VCR    = 8'h81;
  localparam logic [7:0]  CMD_FAST_RD   = 8'h0B;
  localparam logic [7:0]  VCR_RESET     = 8'hFB;
  localparam logic [7:0]  VCR_RSVD_MASK = 8'hFB;
  localparam int          DUMMY_MSB     = 7;
  localparam int          DUMMY_LSB     = 4;
  localparam int          XIP_BIT       = 3;
  localparam int          WRAP_MSB      = 1;
  localparam logic [3:0]  DUMMY_ZERO    = 4'h0;
  localparam logic [3:0]  DUMMY_ALL     = 4'hF;
  localparam logic [3:0]  DUMMY_DEFAULT = 4'hA;
  localparam logic [1:0]  WRAP_16       = 2'h0;
  localparam logic [1:0]  WRAP_32       = 2'h1;
  localparam logic [1:0]  WRAP_64       = 2'h2;
  localparam logic [23:0] MASK_16       = 24'h00_000F;
  localparam logic [23:0] MASK_32       = 24'h00_001F;
  localparam logic [23:0] MASK_64       = 24'h00_003F;
  localparam logic [23:0] ADDR_ONE      = 24'h00_0001;
  localparam int          CMD_BITS      = 8;
  localparam int          ADDR_BITS     = 24;
  localparam int          DATA_BITS     = 8;
  localparam int          XIP_DIGIT_A   = 2;
  localparam int          XIP_DIGIT_B   = 4;
  typedef enum logic [1:0] {FRC_PROTO_EXT, FRC_PROTO_DUAL, FRC_PROTO_QUAD} frc_proto_t;
  // host register map, byte offsets on the ahb-lite slave
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_ADDR      = 8'h04;
  localparam logic [7:0]  REG_WDATA     = 8'h08;
  localparam logic [7:0]  REG_STATUS    = 8'h0C;
  localparam logic [7:0]  REG_RDATA     = 8'h10;
  localparam int          CTRL_START    = 0;
  localparam int          CTRL_OP_LSB   = 1;
  localparam int          CTRL_LEN_LSB  = 3;
  localparam int          CTRL_DUM_LSB  = 8;
  localparam logic [1:0]  OP_RD_VCR     = 2'h0;
  localparam logic [1:0]  OP_WR_VCR     = 2'h1;
  localparam logic [1:0]  OP_FAST_RD    = 2'h2;
endpackage

// [test/frc_link_monitor.sv]
// checker for the serial link: framing, answer timing, sclk shape
// assumes a host divider half period of 6 clock cycles
`timescale 1ns/100ps
module frc_link_monitor (
  input wire logic CLOCK_I,
  input wire logic SYS_RST_I,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe,
  input wire logic miso
);
  logic [5:0] bit_cnt_q;
  logic [7:0] cmd_q;
  // rises seen in this frame; saturates so long reads cannot alias
  always_ff @(posedge sclk)
  begin
    if (cs_n)
    begin
      bit_cnt_q <= 6'h00;
      cmd_q     <= 8'h00;
    end
    else
    begin
      if (bit_cnt_q != 6'h3F)
        bit_cnt_q <= bit_cnt_q + 6'h01;
      if (bit_cnt_q < 6'h08)
        cmd_q <= {cmd_q[6:0], mosi};
    end
  end

  idle_quiet_a: assert property (@(posedge sclk) disable iff (SYS_RST_I)
    cs_n |=> !miso_oe) else $error("miso driven after frame end");
  cmd_quiet_a: assert property (@(posedge sclk) disable iff (SYS_RST_I)
    !cs_n && bit_cnt_q < 6'h08 |-> !miso_oe) else $error("miso driven during command");
  cfg_answer_a: assert property (@(posedge sclk) disable iff (SYS_RST_I)
    !cs_n && bit_cnt_q == 6'h08 && cmd_q == frc_pkg::CMD_RD_VCR |-> miso_oe ##1 miso_oe)
    else $error("config byte not driven after command");
  wr_silent_a: assert property (@(posedge sclk) disable iff (SYS_RST_I)
    !cs_n && bit_cnt_q >= 6'h08 && cmd_q == frc_pkg::CMD_WR_VCR |-> !miso_oe)
    else $error("miso driven during config write");
  addr_quiet_a: assert property (@(posedge sclk) disable iff (SYS_RST_I)
    !cs_n && cmd_q == frc_pkg::CMD_FAST_RD && bit_cnt_q inside {[8:32]} |-> !miso_oe)
    else $error("read data before address and dummies");
  dummy_span_a: assert property (@(posedge sclk) disable iff (SYS_RST_I)
    !cs_n && $rose(miso_oe) && cmd_q == frc_pkg::CMD_FAST_RD |-> bit_cnt_q inside {[33:46]})
    else $error("read data start outside dummy range");
  sclk_shape_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    $rose(sclk) |-> sclk [*6] ##1 !sclk) else $error("sclk high phase wrong length");
  fall_launch_a: assert property (@(posedge CLOCK_I) disable iff (SYS_RST_I)
    $changed({cs_n, mosi}) |-> !sclk) else $error("host line moved while sclk high");
endmodule // frc_link_monitor

// [test/tb.sv]
// testbench joining host and device ends over one link interface
// assumes one ahb master (this bench) and a combinational array model
`timescale 1ns/100ps
module tb;
  logic                clk    = 1'b0;
  logic                rst_h  = 1'b1;
  logic                rst_d  = 1'b1;
  logic                hsel   = 1'b0;
  logic [31:0]         haddr  = 32'h0000_0000;
  logic [1:0]          htrans = 2'h0;
  logic                hwrite = 1'b0;
  logic [31:0]         hwdata = 32'h0000_0000;
  logic [31:0]         hrdata;
  logic                hready;
  logic                hresp;
  logic [1:0]          nv     = 2'h3;
  logic [23:0]         mem_addr;
  logic [7:0]          mem_q;
  logic [3:0]          dum;
  logic                execute_in_place_enable;
  logic [1:0]          wrap;
  frc_pkg::frc_proto_t proto;
  logic [31:0]         rd;
  logic [31:0]         ex;
  logic [7:0]          v;
  logic [23:0]         a;
  integer              seed       = 32'hd78b_8170;
  int                  fail_count = 0;
  int                  n_checks   = 0;

  function automatic logic [7:0] mem_byte(input logic [23:0] ad);
    return ad[7:0] ^ ad[23:16];
  endfunction
  function automatic logic [3:0] eff_dum(input logic [7:0] c);
    return (c[7:4] == 4'h0 || c[7:4] == 4'hF) ? 4'hA : c[7:4];
  endfunction
  // next byte address: wrap inside the aligned block, else count on
  function automatic logic [23:0] nxt(input logic [23:0] ad, input logic [1:0] w);
    logic [23:0] m;
    m = (w == 2'h0) ? 24'h00_000F : (w == 2'h1) ? 24'h00_001F : 24'h00_003F;
    return (w == 2'h3) ? ad + 24'h00_0001 : (ad & ~m) | ((ad + 24'h00_0001) & m);
  endfunction

  assign mem_q = mem_byte(mem_addr);
  always #2 clk = ~clk;

  frc_link_if link ();
  frc_host #(.HALF_DIV(6)) u_frc_host (.CLOCK_I(clk), .SYS_RST_I(rst_h), .HSEL_I(hsel),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
    .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
    .LINK(link.host));
  frc_device #(.FEATURE_DIGIT(1)) u_frc_device (.LINK(link.dev), .SYS_RST_I(rst_d),
    .NV_PROTO_I(nv), .MEM_DATA_I(mem_q), .MEM_ADDR_O(mem_addr), .DUMMY_CYCLES_O(dum),
    .XIP_ACTIVE_O(execute_in_place_enable), .WRAP_MODE_O(wrap), .PROTOCOL_O(proto));
  frc_link_monitor u_frc_link_monitor (.CLOCK_I(clk), .SYS_RST_I(rst_h), .sclk(link.sclk),
    .cs_n(link.cs_n), .mosi(link.mosi), .miso_o(link.miso_o), .miso_oe(link.miso_oe),
    .miso(link.miso));

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // entered just after a rising edge, returns on one
  task automatic ahb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h00_0000, ad};
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  task automatic op(input logic [1:0] code, input logic [23:0] ad, input logic [7:0] wd,
                    input logic [1:0] len, input logic [3:0] dc);
    ahb(1'b1, frc_pkg::REG_ADDR, {8'h00, ad});
    ahb(1'b1, frc_pkg::REG_WDATA, {24'h00_0000, wd});
    ahb(1'b1, frc_pkg::REG_CTRL, {20'h0_0000, dc, 3'h0, len, code, 1'b1});
    rd = 32'h0000_0001;
    while (rd[0] !== 1'b0) ahb(1'b0, frc_pkg::REG_STATUS, 32'h0000_0000);
    ahb(1'b0, frc_pkg::REG_RDATA, 32'h0000_0000);
    // let device side outputs settle in the link domain
    repeat (2) @(posedge link.sclk);
    @(posedge clk);
  endtask
  // device reset must span sclk rises, so host leaves reset first
  task automatic do_reset(input logic [1:0] p);
    nv    <= p;
    rst_h <= 1'b1;
    rst_d <= 1'b1;
    repeat (3) @(posedge clk);
    rst_h <= 1'b0;
    repeat (3) @(posedge link.sclk);
    rst_d <= 1'b0;
    @(posedge link.sclk);
    @(posedge clk);
  endtask

  initial
  begin
    repeat (90000) @(posedge clk);
    fail_count++;
    conclude();
  end

  initial
  begin
    for (int i = 0; i < 4; i++)
    begin
      do_reset(i[1:0]);
      ex = (i == 3) ? 32'h0000_0000 : (i == 2) ? 32'h0000_0001 : 32'h0000_0002;
      chk({30'h0000_0000, proto}, ex);
      chk({24'h00_0000, dum, 1'b0, execute_in_place_enable, wrap}, {24'h00_0000, 4'hA, 1'b0, 1'b0, 2'h3});
      op(frc_pkg::OP_RD_VCR, 24'h00_0000, 8'h00, 2'h0, 4'h0);
      chk({24'h00_0000, rd[7:0]}, {24'h00_0000, frc_pkg::VCR_RESET});
    end
    ahb(1'b1, 8'h20, 32'hFFFF_FFFF);
    ahb(1'b0, 8'h20, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk({31'h0000_0000, hresp}, 32'h0000_0000);
    for (int i = 0; i < 14; i++)
    begin
      v = (i == 0) ? 8'h0B : (i == 1) ? 8'hF8 : (i == 3) ? 8'h39 : (i == 5) ? 8'hCA
        : 8'($random(seed));
      a = (i == 0) ? 24'hFF_FFFE : 24'($random(seed));
      // odd starts sit two bytes below a 64-byte line, so every wrap size folds
      if (i[0])
        a[5:0] = 6'h3E;
      op(frc_pkg::OP_WR_VCR, 24'h00_0000, v, 2'h0, 4'h0);
      chk({28'h000_0000, dum}, {28'h000_0000, eff_dum(v)});
      chk({31'h0000_0000, execute_in_place_enable}, {31'h0000_0000, ~v[3]});
      chk({30'h0000_0000, wrap}, {30'h0000_0000, v[1:0]});
      op(frc_pkg::OP_RD_VCR, 24'h00_0000, 8'h00, 2'h0, 4'h0);
      chk({24'h00_0000, rd[7:0]}, {24'h00_0000, v & frc_pkg::VCR_RSVD_MASK});
      if (v[3])
      begin
        op(frc_pkg::OP_FAST_RD, a, 8'h00, 2'h3, eff_dum(v));
        ex = 32'h0000_0000;
        for (int k = 0; k < 4; k++)
        begin
          ex = {ex[23:0], mem_byte(a)};
          a = nxt(a, v[1:0]);
        end
        chk(rd, ex);
      end
    end
    conclude();
  end
endmodule // tb
